// ==== src/timing_pin_router.sv ====
// Purpose: routes timing control between function pins and internal timing signals
// Assumes: one 100 MHz clock; configuration ports held stable by software
// Notes:   acquisition sequencing itself lives outside this block
// Contract
// - ten bidirectional function pins carry external timing control
// - driven pins mirror fixed internal signals, no selectable content
// - five dedicated outputs carry the remaining timing signals
// - each of thirteen internal signals selects any pin as source
// - each pin has its own software output driver enable
// - polarity per signal; edge or level selected per signal
// - level detection adds no pulse width limits
// - scan clock leading edge 50 to 100 ns after conversion start
// - scan clock polarity is software selectable
// - scan clock pulse lasts 400 to 500 ns, only when enabled
// - supports posttriggered and pretriggered acquisition signalling
// - all pin drivers come out of reset disabled
// - edge signals react to rising or falling edge per polarity
// - trigger and scan start pin outputs are 50 to 100 ns high pulses
`timescale 1ns/1ns
`default_nettype none
module timing_pin_router
    import timing_pin_pkg::*;
(
    input  wire logic                                   clk_i,
    input  wire logic                                   rst_b_i,
    // function pin triplets
    input  wire logic [timing_pin_pkg::NUM_PINS-1:0]    function_pins_i,
    output logic      [timing_pin_pkg::NUM_PINS-1:0]    function_pins_o,
    output logic      [timing_pin_pkg::NUM_PINS-1:0]    function_pins_oe_o,
    // software configuration
    input  wire timing_pin_pkg::route_cfg_t             route_cfg_i,
    input  wire logic [timing_pin_pkg::NUM_PINS-1:0]    drive_en_i,
    input  wire logic                                   scan_clock_en_i,
    input  wire logic                                   scan_clock_invert_i,
    input  wire logic                                   pretrigger_mode_i,
    // internal timing sources and internal fixed outputs
    input  wire logic [timing_pin_pkg::NUM_SIGS-1:0]    internal_src_i,
    input  wire logic [timing_pin_pkg::NUM_PINS-1:0]    pin_out_src_i,
    input  wire logic [timing_pin_pkg::NUM_DEDICATED-1:0] dedicated_src_i,
    input  wire logic                                   acq_trigger_evt_i,
    input  wire logic                                   posttrigger_evt_i,
    input  wire logic                                   scan_start_evt_i,
    input  wire logic                                   convert_start_i,
    // results
    output logic      [timing_pin_pkg::NUM_SIGS-1:0]    timing_sig_o,
    output logic      [timing_pin_pkg::NUM_DEDICATED-1:0] dedicated_o,
    output logic                                        scan_clock_out_o
);
    import timing_pin_pkg::*;

    logic [NUM_PINS-1:0] pin_synced;
    logic [2:0]          warm_q;
    logic [2:0]          warm_d;
    logic [NUM_PINS-1:0] pin_prev_q;
    logic [NUM_PINS-1:0] pin_prev_d;
    logic [NUM_SIGS-1:0] sig_q;
    logic [NUM_SIGS-1:0] sig_d;
    logic [NUM_PINS-1:0] pin_out_q;
    logic [NUM_PINS-1:0] pin_out_d;
    logic [NUM_PINS-1:0] oe_q;
    logic [NUM_PINS-1:0] oe_d;
    logic [NUM_DEDICATED-1:0] ded_q;
    logic [NUM_DEDICATED-1:0] ded_d;
    logic                acq_trigger_pulse;
    logic                posttrigger_pulse;
    logic                scan_start_pulse;
    logic                posttrigger_gated;

    // synchronise before any detection so one edge gives one pulse
    pin_sync u_sync (
        .clk_i   (clk_i),
        .rst_b_i (rst_b_i),
        .pin_i   (function_pins_i),
        .sync_o  (pin_synced)
    );

    always_comb
    begin
        pin_prev_d = pin_synced;
        // edges wait until sync and history hold real levels: an idle-high
        // pin must not look like a fresh edge just after reset
        warm_d     = {warm_q[1:0], 1'b1};
    end

    // per signal source selection, polarity and detection
    generate
        for (genvar s = 0; s < NUM_SIGS; s++)
        begin : g_sig
            logic [SEL_W-1:0] sel;
            logic             raw_now;
            logic             raw_prev;
            logic             lvl_now;
            logic             lvl_prev;
            always_comb
            begin
                sel      = route_cfg_i.pin_sel[s];
                raw_now  = 1'b0;
                raw_prev = 1'b0;
                if (sel < SEL_W'(NUM_PINS))
                begin
                    raw_now  = pin_synced[sel];
                    raw_prev = pin_prev_q[sel];
                end
                lvl_now  = raw_now ^ route_cfg_i.invert[s];
                lvl_prev = raw_prev ^ route_cfg_i.invert[s];
                if (!route_cfg_i.ext_en[s])
                    sig_d[s] = internal_src_i[s];
                else if (route_cfg_i.edge_mode[s])
                    sig_d[s] = lvl_now & ~lvl_prev & warm_q[2];
                else
                    sig_d[s] = lvl_now;
            end
        end
    endgenerate

    // trigger and start-of-scan pin outputs are stretched pulses
    pulse_stretch #(.WIDTH(CNT_W'(PULSE_CYC))) u_trig_pulse (
        .clk_i   (clk_i),
        .rst_b_i (rst_b_i),
        .event_i (acq_trigger_evt_i),
        .pulse_o (acq_trigger_pulse)
    );

    // the post-trigger marker only exists in pretriggered runs
    assign posttrigger_gated = posttrigger_evt_i & pretrigger_mode_i;

    pulse_stretch #(.WIDTH(CNT_W'(PULSE_CYC))) u_post_pulse (
        .clk_i   (clk_i),
        .rst_b_i (rst_b_i),
        .event_i (posttrigger_gated),
        .pulse_o (posttrigger_pulse)
    );

    pulse_stretch #(.WIDTH(CNT_W'(PULSE_CYC))) u_scan_pulse (
        .clk_i   (clk_i),
        .rst_b_i (rst_b_i),
        .event_i (scan_start_evt_i),
        .pulse_o (scan_start_pulse)
    );

    // fixed pin contents: no mux, each pin mirrors its own signal
    always_comb
    begin
        pin_out_d                  = pin_out_src_i;
        pin_out_d[SIG_ACQ_TRIGGER] = acq_trigger_pulse;
        pin_out_d[SIG_POST_MARKER] = posttrigger_pulse;
        pin_out_d[SIG_SCAN_START]  = scan_start_pulse;
        oe_d                       = drive_en_i;
        ded_d                      = dedicated_src_i;
    end

    // scan clock sequencer
    scan_state_t      sc_state_q;
    scan_state_t      sc_state_d;
    logic [CNT_W-1:0] sc_cnt_q;
    logic [CNT_W-1:0] sc_cnt_d;
    logic             sc_out_q;
    logic             sc_out_d;

    always_comb
    begin
        sc_state_d = sc_state_q;
        sc_cnt_d   = sc_cnt_q;
        case (sc_state_q)
            SC_IDLE:
            begin
                if (convert_start_i && scan_clock_en_i)
                begin
                    sc_state_d = SC_DELAY;
                    sc_cnt_d   = CNT_W'(SCAN_DELAY_CYC - 1);
                end
            end
            SC_DELAY:
            begin
                if (sc_cnt_q == '0)
                begin
                    sc_state_d = SC_PULSE;
                    sc_cnt_d   = CNT_W'(SCAN_WIDTH_CYC - 1);
                end
                else
                    sc_cnt_d = sc_cnt_q - CNT_W'(1);
            end
            SC_PULSE:
            begin
                if (sc_cnt_q == '0)
                    sc_state_d = SC_IDLE;
                else
                    sc_cnt_d = sc_cnt_q - CNT_W'(1);
            end
            default:
            begin
                sc_state_d = SC_IDLE;
                sc_cnt_d   = '0;
            end
        endcase
        sc_out_d = (sc_state_d == SC_PULSE) ^ scan_clock_invert_i;
    end

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            pin_prev_q <= '0;
            warm_q     <= '0;
            sig_q      <= '0;
            pin_out_q  <= '0;
            oe_q       <= DRIVE_RESET;
            ded_q      <= '0;
            sc_state_q <= SC_IDLE;
            sc_cnt_q   <= '0;
            sc_out_q   <= POL_RESET;
        end
        else
        begin
            pin_prev_q <= pin_prev_d;
            warm_q     <= warm_d;
            sig_q      <= sig_d;
            pin_out_q  <= pin_out_d;
            oe_q       <= oe_d;
            ded_q      <= ded_d;
            sc_state_q <= sc_state_d;
            sc_cnt_q   <= sc_cnt_d;
            sc_out_q   <= sc_out_d;
        end
    end

    // the far side must release a pin whose driver is on
    assign function_pins_o    = pin_out_q;
    assign function_pins_oe_o = oe_q;
    assign timing_sig_o       = sig_q;
    assign dedicated_o        = ded_q;
    assign scan_clock_out_o   = sc_out_q;
endmodule // timing_pin_router
`default_nettype wire

// ==== shared/timing_pin_pkg.sv ====
// Purpose: shared constants and carriers for the timing pin router
// Assumes: 100 MHz module clock
// Notes:   pin and signal indices follow the fixed output assignment
package timing_pin_pkg;
    localparam int NUM_PINS     = 10;
    localparam int NUM_SIGS     = 13;
    localparam int NUM_DEDICATED = 5;
    localparam int SEL_W        = 4;
    localparam int CLK_PERIOD_NS = 10;

    // scan clock timing, as printed
    localparam int SCAN_DELAY_MIN_NS = 50;
    localparam int SCAN_DELAY_MAX_NS = 100;
    localparam int SCAN_WIDTH_MIN_NS = 400;
    localparam int SCAN_WIDTH_MAX_NS = 500;
    // trigger and start-of-scan output pulse width
    localparam int PULSE_MIN_NS      = 50;
    localparam int PULSE_MAX_NS      = 100;
    // least input pulse width in edge mode, kept by the source
    localparam int EDGE_MIN_NS       = 10;

    localparam int SCAN_DELAY_CYC =
        (SCAN_DELAY_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SCAN_WIDTH_CYC =
        (SCAN_WIDTH_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PULSE_CYC =
        (PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 8;

    // internal signal indices that have a fixed home pin
    localparam int SIG_ACQ_TRIGGER  = 0;
    localparam int SIG_POST_MARKER  = 1;
    localparam int SIG_CONVERT      = 2;
    localparam int SIG_SCAN_START   = 7;

    localparam logic [NUM_PINS-1:0] DRIVE_RESET = 10'h000;
    localparam logic                POL_RESET   = 1'b0;

    typedef struct packed {
        logic [NUM_SIGS-1:0]            ext_en;
        logic [NUM_SIGS-1:0]            invert;
        logic [NUM_SIGS-1:0]            edge_mode;
        logic [NUM_SIGS-1:0][SEL_W-1:0] pin_sel;
    } route_cfg_t;

    typedef struct packed {
        logic [NUM_PINS-1:0] in;
        logic [NUM_PINS-1:0] out;
        logic [NUM_PINS-1:0] oe;
    } pin_bus_t;

    typedef enum logic [2:0] {
        SC_IDLE  = 3'b001,
        SC_DELAY = 3'b010,
        SC_PULSE = 3'b100
    } scan_state_t;
endpackage

// ==== src/pin_sync.sv ====
// Purpose: two-stage synchroniser for the function pin inputs
// Assumes: pins are asynchronous to clk_i
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ns
`default_nettype none
module pin_sync
    import timing_pin_pkg::*;
(
    input  wire logic                clk_i,
    input  wire logic                rst_b_i,
    input  wire logic [NUM_PINS-1:0] pin_i,
    output logic      [NUM_PINS-1:0] sync_o
);
    logic [NUM_PINS-1:0] meta_q;
    logic [NUM_PINS-1:0] meta_d;
    logic [NUM_PINS-1:0] sync_q;
    logic [NUM_PINS-1:0] sync_d;

    always_comb
    begin
        meta_d = pin_i;
        sync_d = meta_q;
    end

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            meta_q <= '0;
            sync_q <= '0;
        end
        else
        begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_o = sync_q;
endmodule // pin_sync
`default_nettype wire

// ==== src/pulse_stretch.sv ====
// Purpose: turns a one-cycle event into an active-high pulse of fixed width
// Assumes: events spaced at least WIDTH cycles apart
// Notes:   an event during a pulse restarts it
`timescale 1ns/1ns
`default_nettype none
module pulse_stretch
    import timing_pin_pkg::*;
#(
    parameter logic [CNT_W-1:0] WIDTH = CNT_W'(PULSE_CYC)
)
(
    input  wire logic clk_i,
    input  wire logic rst_b_i,
    input  wire logic event_i,
    output logic      pulse_o
);
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic             pulse_q;
    logic             pulse_d;

    always_comb
    begin
        cnt_d   = cnt_q;
        pulse_d = 1'b0;
        if (event_i)
        begin
            cnt_d   = WIDTH;
            pulse_d = 1'b1;
        end
        else if (cnt_q > CNT_W'(1))
        begin
            cnt_d   = cnt_q - CNT_W'(1);
            pulse_d = 1'b1;
        end
        else
        begin
            cnt_d = '0;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            cnt_q   <= '0;
            pulse_q <= 1'b0;
        end
        else
        begin
            cnt_q   <= cnt_d;
            pulse_q <= pulse_d;
        end
    end

    assign pulse_o = pulse_q;
endmodule // pulse_stretch
`default_nettype wire

// ==== testbench/timing_pin_router_monitor.sv ====
// Purpose: port checks for timing_pin_router
// Assumes: scan clock polarity is changed only while in reset
// Notes:   bound to every router instance
`timescale 1ns/1ns
`default_nettype none
module timing_pin_router_monitor
    import timing_pin_pkg::*;
(
    input wire logic                     clk_i,
    input wire logic                     rst_b_i,
    input wire logic [NUM_PINS-1:0]      function_pins_o,
    input wire logic [NUM_PINS-1:0]      function_pins_oe_o,
    input wire logic [NUM_PINS-1:0]      drive_en_i,
    input wire logic [NUM_PINS-1:0]      pin_out_src_i,
    input wire route_cfg_t               route_cfg_i,
    input wire logic [NUM_SIGS-1:0]      internal_src_i,
    input wire logic [NUM_SIGS-1:0]      timing_sig_o,
    input wire logic [NUM_DEDICATED-1:0] dedicated_src_i,
    input wire logic [NUM_DEDICATED-1:0] dedicated_o,
    input wire logic                     scan_clock_en_i,
    input wire logic                     scan_clock_invert_i,
    input wire logic                     scan_clock_out_o,
    input wire logic                     pretrigger_mode_i,
    input wire logic                     acq_trigger_evt_i,
    input wire logic                     posttrigger_evt_i,
    input wire logic                     scan_start_evt_i,
    input wire logic                     convert_start_i
);
    logic       act;
    logic       take;
    logic [7:0] act_q, act_d, bsy_q, bsy_d;
    assign act  = scan_clock_out_o ^ scan_clock_invert_i;
    assign take = convert_start_i && scan_clock_en_i && bsy_q == 8'h00;
    // busy shadow: starts inside the 45-cycle window are dropped by the router
    always_comb
    begin
        act_d = act ? act_q + 8'h01 : 8'h00;
        bsy_d = take ? 8'h2D : bsy_q - {7'h00, bsy_q != 8'h00};
    end
    always_ff @(posedge clk_i or negedge rst_b_i)
        if (!rst_b_i)
            {act_q, bsy_q} <= 16'h0000;
        else
            {act_q, bsy_q} <= {act_d, bsy_d};
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    sequence s_lead;
        !act [*6] ##1 act;
    endsequence
    sequence s_trig;
        acq_trigger_evt_i ##1 !acq_trigger_evt_i [*6];
    endsequence
    a_oe_reset: assert property ($rose(rst_b_i) |-> function_pins_oe_o == '0)
        else $error("driver enable set out of reset");
    a_oe_follow: assert property ($past(rst_b_i) |-> function_pins_oe_o == $past(drive_en_i))
        else $error("driver enable not following");
    a_ded_copy: assert property ($past(rst_b_i) |-> dedicated_o == $past(dedicated_src_i))
        else $error("dedicated output wrong");
    a_pin_mirror: assert property ($past(rst_b_i) |-> (function_pins_o & 10'h37C) ==
        ($past(pin_out_src_i) & 10'h37C)) else $error("pin output not mirroring");
    a_int_route: assert property ($past(rst_b_i) |-> ((timing_sig_o ^
        $past(internal_src_i)) & ~$past(route_cfg_i.ext_en)) == '0) else $error("internal route");
    // stretcher and pin register each add a cycle before the pin rises
    a_trig_width: assert property (acq_trigger_evt_i |=> ##1 function_pins_o[0] [*5])
        else $error("trigger pulse short");
    a_trig_end: assert property (s_trig |=> !function_pins_o[0])
        else $error("trigger pulse long");
    a_start_width: assert property (scan_start_evt_i |=> ##1 function_pins_o[7] [*5])
        else $error("scan start pulse short");
    a_post_gate: assert property ($rose(function_pins_o[1]) |->
        $past(posttrigger_evt_i && pretrigger_mode_i, 2)) else $error("marker without cause");
    a_scan_lead: assert property (take |-> s_lead)
        else $error("scan clock lead wrong");
    a_scan_width: assert property (take |-> ##46 (!act && act_q == 8'h28))
        else $error("scan clock width wrong");
    a_scan_off: assert property (!scan_clock_en_i && bsy_q == 8'h00 |=> !act)
        else $error("scan clock while disabled");
endmodule // timing_pin_router_monitor
bind timing_pin_router timing_pin_router_monitor mon_u (.*);
`default_nettype wire

// ==== testbench/ext_trigger_source.sv ====
// Purpose: external trigger source on the function pins
// Assumes: bench asks for levels, the source retimes them to the clock
// Notes:   resolves each pin from both drivers
`timescale 1ns/1ns
`default_nettype none
module ext_trigger_source
    import timing_pin_pkg::*;
(
    input  wire logic                clk_i,
    input  wire logic [NUM_PINS-1:0] level_i,
    input  wire logic [NUM_PINS-1:0] dut_oe_i,
    input  wire logic [NUM_PINS-1:0] dut_out_i,
    output logic      [NUM_PINS-1:0] wire_o
);
    logic [NUM_PINS-1:0] drv_q;
    // every level lasts a whole cycle, equal to the 10 ns edge minimum
    always_ff @(posedge clk_i)
        drv_q <= level_i;
    // the source lets go of any pin the router drives
    assign wire_o = (dut_oe_i & dut_out_i) | (~dut_oe_i & drv_q);
endmodule // ext_trigger_source
`default_nettype wire

// ==== testbench/timing_pin_router_tb.sv ====
// Purpose: self-checking bench for timing_pin_router
// Assumes: exact latencies as handed over
// Notes:   polarity of the scan clock is swapped across a second reset
`timescale 1ns/1ns
`default_nettype none
module timing_pin_router_tb;
    import timing_pin_pkg::*;
    logic                     clk_i, rst_b_i, scan_clock_out_o;
    logic                     scan_clock_en_i, scan_clock_invert_i, pretrigger_mode_i;
    logic                     acq_trigger_evt_i, posttrigger_evt_i;
    logic                     scan_start_evt_i, convert_start_i;
    logic [NUM_PINS-1:0]      function_pins_i, function_pins_o, function_pins_oe_o;
    logic [NUM_PINS-1:0]      drive_en_i, pin_out_src_i, level_q;
    logic [NUM_SIGS-1:0]      internal_src_i, timing_sig_o;
    logic [NUM_DEDICATED-1:0] dedicated_src_i, dedicated_o;
    route_cfg_t               route_cfg_i, cfg;
    int                       miscompares, cmp_count, cycles, first, hi, s;

    timing_pin_router dut_u (.*);
    ext_trigger_source src_u (.clk_i(clk_i), .level_i(level_q), .dut_oe_i(function_pins_oe_o),
        .dut_out_i(function_pins_o), .wire_o(function_pins_i));

    initial
    begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    task automatic step(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic look(input int n);
        step(n);
        #1;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // counts high cycles of a pin output, or of the active scan clock for k >= 10;
    // sample 1 is taken just after the edge that takes the event
    task automatic fire(input int k, input int n, input int exp);
        logic v;
        step(1);
        case (k)
            0: acq_trigger_evt_i <= 1'b1;
            1: posttrigger_evt_i <= 1'b1;
            7: scan_start_evt_i <= 1'b1;
            default: convert_start_i <= 1'b1;
        endcase
        first = -1;
        hi = 0;
        for (int i = 1; i <= n; i++)
        begin
            @(posedge clk_i);
            if (i == 1)
                {acq_trigger_evt_i, posttrigger_evt_i, scan_start_evt_i, convert_start_i} <= 4'h0;
            #1 v = (k < NUM_PINS) ? function_pins_o[k] : scan_clock_out_o ^ scan_clock_invert_i;
            if (v === 1'b1)
            begin
                hi++;
                if (first < 0)
                    first = i;
            end
        end
        chk(16'(hi), 16'(exp));
    endtask
    task automatic end_sim;
        $display("comparisons %0d miscompares %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles > 3000)
        begin
            miscompares++;
            end_sim;
        end
    end

    initial
    begin
        rst_b_i = 1'b0;
        {scan_clock_en_i, scan_clock_invert_i, pretrigger_mode_i} = 3'h0;
        {acq_trigger_evt_i, posttrigger_evt_i, scan_start_evt_i, convert_start_i} = 4'h0;
        {drive_en_i, pin_out_src_i, level_q} = 30'h0;
        {internal_src_i, dedicated_src_i} = 18'h0;
        route_cfg_i = '0;
        look(7);
        chk(16'(function_pins_oe_o), 16'h0000);
        step(1);
        rst_b_i <= 1'b1;
        step(1);
        drive_en_i <= 10'h2A5;
        pin_out_src_i <= 10'h3C3;
        dedicated_src_i <= 5'h15;
        internal_src_i <= 13'h0AAA;
        look(1);
        chk(16'(function_pins_oe_o), 16'h02A5);
        chk(16'(function_pins_o & 10'h37C), 16'h0340);
        chk(16'(dedicated_o), 16'h0015);
        step(1);
        drive_en_i <= 10'h000;
        // one pin high at a time, so a wrong selection reads low, or high on the inverted odd signals
        for (s = 0; s < NUM_SIGS; s++)
        begin
            cfg = '0;
            cfg.ext_en[s] = 1'b1;
            cfg.invert[s] = s[0];
            cfg.pin_sel[s] = SEL_W'(s % NUM_PINS);
            step(1);
            route_cfg_i <= cfg;
            level_q <= 10'h001 << (s % NUM_PINS);
            look(4);
            chk(16'(timing_sig_o[s]), 16'(!s[0]));
            chk(16'(timing_sig_o & ~cfg.ext_en), 16'(13'h0AAA & ~cfg.ext_en));
            step(1);
            level_q <= 10'h000;
            look(4);
            chk(16'(timing_sig_o[s]), 16'(s[0]));
        end
        cfg = '0;
        cfg.ext_en[SIG_CONVERT] = 1'b1;
        cfg.invert[SIG_CONVERT] = 1'b1;
        cfg.edge_mode[SIG_CONVERT] = 1'b1;
        cfg.pin_sel[SIG_CONVERT] = 4'h9;
        step(1);
        route_cfg_i <= cfg;
        level_q <= 10'h200;
        look(6);
        chk(16'(timing_sig_o[SIG_CONVERT]), 16'h0000);
        step(1);
        level_q <= 10'h000;
        look(4);
        chk(16'(timing_sig_o[SIG_CONVERT]), 16'h0001);
        look(1);
        chk(16'(timing_sig_o[SIG_CONVERT]), 16'h0000);
        cfg.edge_mode[SIG_CONVERT] = 1'b0;
        cfg.pin_sel[SIG_CONVERT] = 4'hA;
        step(1);
        route_cfg_i <= cfg;
        level_q <= 10'h3FF;
        look(4);
        chk(16'(timing_sig_o[SIG_CONVERT]), 16'h0001);
        step(1);
        pretrigger_mode_i <= 1'b1;
        fire(0, 12, PULSE_CYC);
        fire(1, 12, PULSE_CYC);
        fire(7, 12, PULSE_CYC);
        step(1);
        pretrigger_mode_i <= 1'b0;
        fire(1, 12, 0);
        fire(10, 60, 0);
        step(1);
        scan_clock_en_i <= 1'b1;
        fire(10, 60, SCAN_WIDTH_CYC);
        chk(16'(first), 16'(SCAN_DELAY_CYC + 1));
        step(1);
        rst_b_i <= 1'b0;
        scan_clock_invert_i <= 1'b1;
        step(8);
        rst_b_i <= 1'b1;
        look(2);
        chk(16'(scan_clock_out_o), 16'h0001);
        fire(10, 60, SCAN_WIDTH_CYC);
        chk(16'(first), 16'(SCAN_DELAY_CYC + 1));
        end_sim;
    end
endmodule // timing_pin_router_tb
`default_nettype wire
